// ==== core/pin_select_defs.vh ====
// Constants for the pin select, port read and pull-up control block
// How it works
// - Interrupt-1 pin field bits 3..1 routes P1_7 for 000, P1_5 for 001, P2_0 for 010; other codes are not written.
// - Software writes zero to reserved and unassigned bits, and unassigned bits always read back as zero.
// - With port read select at 0 a port read gives pin level for input bits and latch value for output bits.
// - With port read select at 1 a port read gives the pin level for every bit except P4_2, whatever its direction.
// - Port read select acts on every port pin except P4_2, which keeps the direction-dependent read.
// - I2C double-rate bit 4 at 1 doubles the rate chosen by the I2C clock select field, at 0 leaves it.
// - I2C half-rate bit 5 at 1 halves the rate chosen by the I2C clock select field, at 0 leaves it.
// - SDA delay field bits 7..6 delays SDA by 3, 11 or 19 system clocks for 00, 01, 10; 11 is not allowed.
// - Each pull-up enable bit covers one pin group as laid out below, and bit 5 is reserved.
// - An enabled pull-up acts only on pins of its group whose direction bit is 0.
`ifndef PIN_SELECT_DEFS_VH
`define PIN_SELECT_DEFS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define IRQ_PIN_SEL_IDX 12'h18E
`define IO_FUNC_SEL_IDX 12'h18F
`define PULLUP_CTRL0_IDX 12'h1E0
`define REG_ADDR_W 12
`define REG_IDX_LSB 2

// ----------------------------------------------------------------
// Writable and readable masks, reset values
// ----------------------------------------------------------------
`define IRQ_PIN_SEL_MASK 8'hDE
`define IO_FUNC_SEL_MASK 8'hFB
`define PULLUP_CTRL0_MASK 8'hFF
`define REG_RESET 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRQ1_SEL_HI 3
`define IRQ1_SEL_LO 1
`define IRQ1_SEL_P1_7 3'h0
`define IRQ1_SEL_P1_5 3'h1
`define IRQ1_SEL_P2_0 3'h2
`define PORT_READ_SEL_BIT 3
`define RATE_DOUBLE_BIT 4
`define RATE_HALF_BIT 5
`define SDA_DLY_HI 7
`define SDA_DLY_LO 6
`define SDA_DLY_3 2'h0
`define SDA_DLY_11 2'h1

// ----------------------------------------------------------------
// SDA delay taps, in system clock cycles
// ----------------------------------------------------------------
`define SDA_DLY_SHORT 3
`define SDA_DLY_MID 11
`define SDA_DLY_LONG 19

// ----------------------------------------------------------------
// Port layout: five 8-bit ports, pin index = port * 8 + bit
// ----------------------------------------------------------------
`define PORT_PINS 40
`define PIN_P4_2 34

`endif

// ==== core/pin_select_port_read_pullup.v ====
// Pin routing, port read source, I2C rate, SDA delay and pull-up control
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "pin_select_defs.vh"

module pin_select_port_read_pullup
(
  // Clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Interrupt-1 candidate pins and routed input
  input wire irq1_src_p1_7_i,
  input wire irq1_src_p1_5_i,
  input wire irq1_src_p2_0_i,
  output wire ext_irq_one_input_o,
  // Port read path
  input wire [39:0] pin_level_i,
  input wire [39:0] port_latch_i,
  input wire [39:0] port_direction_reg_i,
  output wire [39:0] port_read_data_o,
  // I2C rate control
  output wire i2c_rate_double_o,
  output wire i2c_rate_half_o,
  // SDA digital delay
  input wire sda_i,
  output wire sda_delayed_o,
  // Pull-up enables, one per pin
  output wire [39:0] pullup_en_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word index from byte address; lower two bits are ignored
  function [9:0] word_idx;
    input [11:0] addr;
    begin
      word_idx = addr[`REG_ADDR_W-1:`REG_IDX_LSB];
    end
  endfunction

  // Pull-up group enable for a given pin, from the pull-up register
  function group_en;
    input integer pin;
    input [7:0] pur;
    begin
      group_en = 1'b0;
      if (pin >= 0 && pin <= 3)
        group_en = pur[0];
      else if (pin >= 4 && pin <= 7)
        group_en = pur[1];
      else if (pin >= 8 && pin <= 11)
        group_en = pur[2];
      else if (pin >= 12 && pin <= 15)
        group_en = pur[3];
      else if (pin >= 16 && pin <= 18)
        group_en = pur[4];
      else if (pin == 25 || pin == 27)
        group_en = pur[6];
      else if (pin == 28 || pin == 29 || pin == 31)
        group_en = pur[7];
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] irq_pin_select_r;
  reg [7:0] io_function_pin_select_r;
  reg [7:0] pullup_control_0_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg ext_irq_one_input_r;
  reg [39:0] port_read_data_r;
  reg i2c_rate_double_r;
  reg i2c_rate_half_r;
  reg [`SDA_DLY_LONG-2:0] sda_shift_r;
  reg sda_delayed_r;
  reg [39:0] pullup_en_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [`REG_ADDR_W-1:0] idx;
  wire setup_phase;
  wire access_done;
  wire wr_en;
  reg hit_irq;
  reg hit_io;
  reg hit_pur;
  reg [7:0] rd_byte;

  assign idx = {2'h0, word_idx(paddr_i)};
  assign setup_phase = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_r;
  assign wr_en = access_done & pwrite_i & pstrb_i[0];

  always @*
  begin
    hit_irq = 1'b0;
    hit_io = 1'b0;
    hit_pur = 1'b0;
    rd_byte = 8'h00;
    if (idx == `IRQ_PIN_SEL_IDX)
    begin
      hit_irq = 1'b1;
      rd_byte = irq_pin_select_r & `IRQ_PIN_SEL_MASK;
    end
    else if (idx == `IO_FUNC_SEL_IDX)
    begin
      hit_io = 1'b1;
      rd_byte = io_function_pin_select_r & `IO_FUNC_SEL_MASK;
    end
    else if (idx == `PULLUP_CTRL0_IDX)
    begin
      hit_pur = 1'b1;
      rd_byte = pullup_control_0_r;
    end
  end

  // Answer is prepared in the setup cycle so every bus output is a flop;
  // the cost is one fixed wait-free access phase, never more.
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= setup_phase;
      // Error flag stands only alongside pready
      pslverr_r <= setup_phase & ~(hit_irq | hit_io | hit_pur);
      if (setup_phase)
      begin
        prdata_r <= pwrite_i ? 32'h00000000 : {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Unassigned bits are never stored, so they can only read zero
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      irq_pin_select_r <= `REG_RESET;
      io_function_pin_select_r <= `REG_RESET;
      pullup_control_0_r <= `REG_RESET;
    end
    else if (wr_en)
    begin
      if (hit_irq)
        irq_pin_select_r <= pwdata_i[7:0] & `IRQ_PIN_SEL_MASK;
      else if (hit_io)
        io_function_pin_select_r <= pwdata_i[7:0] & `IO_FUNC_SEL_MASK;
      else if (hit_pur)
        pullup_control_0_r <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt-1 pin routing
  // ----------------------------------------------------------------
  wire [2:0] irq1_sel;
  reg irq1_mux;

  assign irq1_sel = irq_pin_select_r[`IRQ1_SEL_HI:`IRQ1_SEL_LO];

  // Forbidden codes give an idle-high input so no false request appears
  always @*
  begin
    case (irq1_sel)
      `IRQ1_SEL_P1_7: irq1_mux = irq1_src_p1_7_i;
      `IRQ1_SEL_P1_5: irq1_mux = irq1_src_p1_5_i;
      `IRQ1_SEL_P2_0: irq1_mux = irq1_src_p2_0_i;
      default: irq1_mux = 1'b1;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      ext_irq_one_input_r <= 1'b1;
    else
      ext_irq_one_input_r <= irq1_mux;
  end

  // ----------------------------------------------------------------
  // Port read source and pull-ups
  // ----------------------------------------------------------------
  wire port_read_source_sel;
  wire [39:0] port_read_nxt;
  wire [39:0] pullup_nxt;

  assign port_read_source_sel = io_function_pin_select_r[`PORT_READ_SEL_BIT];

  genvar g;
  generate
    for (g = 0; g < `PORT_PINS; g = g + 1)
    begin : pin_gen
      if (g == `PIN_P4_2)
      begin : fixed_read
        assign port_read_nxt[g] = port_direction_reg_i[g] ? port_latch_i[g] :
                                  pin_level_i[g];
      end
      else
      begin : sel_read
        assign port_read_nxt[g] = (port_read_source_sel | ~port_direction_reg_i[g]) ?
                                  pin_level_i[g] : port_latch_i[g];
      end
      assign pullup_nxt[g] = group_en(g, pullup_control_0_r) &
                             ~port_direction_reg_i[g];
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      port_read_data_r <= 40'h0000000000;
      pullup_en_r <= 40'h0000000000;
    end
    else
    begin
      port_read_data_r <= port_read_nxt;
      pullup_en_r <= pullup_nxt;
    end
  end

  // ----------------------------------------------------------------
  // I2C rate control
  // ----------------------------------------------------------------
  // The rate unit scales its chosen rate by these; both set cancels out
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      i2c_rate_double_r <= 1'b0;
      i2c_rate_half_r <= 1'b0;
    end
    else
    begin
      i2c_rate_double_r <= io_function_pin_select_r[`RATE_DOUBLE_BIT] &
                           ~io_function_pin_select_r[`RATE_HALF_BIT];
      i2c_rate_half_r <= io_function_pin_select_r[`RATE_HALF_BIT] &
                         ~io_function_pin_select_r[`RATE_DOUBLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // SDA digital delay
  // ----------------------------------------------------------------
  // Stage k of the shift line holds SDA delayed by k+1 cycles; the
  // output flop adds one more, so tap N-2 gives a delay of N.
  wire [1:0] sda_dly_sel;
  reg sda_tap;

  assign sda_dly_sel = io_function_pin_select_r[`SDA_DLY_HI:`SDA_DLY_LO];

  always @*
  begin
    case (sda_dly_sel)
      `SDA_DLY_3: sda_tap = sda_shift_r[`SDA_DLY_SHORT-2];
      `SDA_DLY_11: sda_tap = sda_shift_r[`SDA_DLY_MID-2];
      default: sda_tap = sda_shift_r[`SDA_DLY_LONG-2];
    endcase
  end

  // Line idles high after reset, matching a released bus
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sda_shift_r <= {(`SDA_DLY_LONG-1){1'b1}};
      sda_delayed_r <= 1'b1;
    end
    else
    begin
      sda_shift_r <= {sda_shift_r[`SDA_DLY_LONG-3:0], sda_i};
      sda_delayed_r <= sda_tap;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign ext_irq_one_input_o = ext_irq_one_input_r;
  assign port_read_data_o = port_read_data_r;
  assign i2c_rate_double_o = i2c_rate_double_r;
  assign i2c_rate_half_o = i2c_rate_half_r;
  assign sda_delayed_o = sda_delayed_r;
  assign pullup_en_o = pullup_en_r;

endmodule // pin_select_port_read_pullup

// ==== tb/pin_select_properties.sv ====
// Port-level checker for the pin select block
`timescale 1ns/10ps
`include "pin_select_defs.vh"
module pin_select_checker
(
  // Clock, reset and APB
  input wire clk_i,
  input wire reset_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Pin side
  input wire irq1_src_p1_7_i,
  input wire irq1_src_p1_5_i,
  input wire irq1_src_p2_0_i,
  input wire ext_irq_one_input_o,
  input wire [39:0] pin_level_i,
  input wire [39:0] port_latch_i,
  input wire [39:0] port_direction_reg_i,
  input wire [39:0] port_read_data_o,
  input wire i2c_rate_double_o,
  input wire i2c_rate_half_o,
  input wire sda_i,
  input wire sda_delayed_o,
  input wire [39:0] pullup_en_o
);
  localparam [11:0] irq_a = `IRQ_PIN_SEL_IDX << 2;
  localparam [11:0] io_a = `IO_FUNC_SEL_IDX << 2;
  localparam [39:0] p42 = 40'h1 << `PIN_P4_2;
  reg [7:0] irq_r;
  reg [7:0] io_r;
  reg [4:0] quiet_r;
  wire [11:0] wa = {paddr_i[11:2], 2'b00};
  wire wr = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
  wire [2:0] cd = irq_r[3:1];
  wire mux = cd == 3'h0 ? irq1_src_p1_7_i : cd == 3'h1 ? irq1_src_p1_5_i :
    cd == 3'h2 ? irq1_src_p2_0_i : 1'b1;
  wire [39:0] dd = (pin_level_i & ~port_direction_reg_i) |
    (port_latch_i & port_direction_reg_i);
  // Shadows follow writes; quiet counts cycles since one, so config switches settle
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      irq_r <= 8'h00;
      io_r <= 8'h00;
      quiet_r <= 5'h00;
    end
    else
    begin
      if (wr && wa == irq_a) irq_r <= pwdata_i[7:0];
      if (wr && wa == io_a) io_r <= pwdata_i[7:0];
      if (wr) quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence rd_acc;
    psel_i && penable_i && pready_o && !pwrite_i;
  endsequence
  sequence settled;
    quiet_r > 5'h01;
  endsequence
  AST_ZERO_BITS: assert property (rd_acc |-> prdata_o[31:8] == 24'h000000 &&
    !(wa == irq_a && (prdata_o[0] || prdata_o[5])) && !(wa == io_a && prdata_o[2]))
    else $error("unassigned bits read nonzero");
  AST_IRQ_ROUTE: assert property (settled |-> ext_irq_one_input_o == $past(mux))
    else $error("interrupt pin routing wrong");
  AST_READ_DIR: assert property (settled ##0 !$past(io_r[3]) |->
    port_read_data_o == $past(dd)) else $error("direction read wrong");
  AST_READ_PIN: assert property (settled ##0 $past(io_r[3]) |->
    ((port_read_data_o ^ $past(pin_level_i)) & ~p42) == 40'h0) else $error("pin read wrong");
  AST_P42_FIXED: assert property (settled |->
    port_read_data_o[`PIN_P4_2] == $past(dd[`PIN_P4_2])) else $error("P4_2 read wrong");
  AST_RATE: assert property (settled |-> i2c_rate_double_o == $past(io_r[4] & ~io_r[5]) &&
    i2c_rate_half_o == $past(io_r[5] & ~io_r[4])) else $error("rate outputs wrong");
  AST_SDA_DELAY: assert property (quiet_r > 5'h14 |-> sda_delayed_o ==
    (io_r[7:6] == 2'h0 ? $past(sda_i, 3) : io_r[7:6] == 2'h1 ? $past(sda_i, 11) :
    $past(sda_i, 19))) else $error("SDA delay wrong");
  AST_PULLUP_INPUT: assert property ((pullup_en_o & $past(port_direction_reg_i)) == 40'h0)
    else $error("pull-up on output pin");
endmodule // pin_select_checker

bind pin_select_port_read_pullup pin_select_checker pin_select_checker_inst
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq1_src_p1_7_i(irq1_src_p1_7_i), .irq1_src_p1_5_i(irq1_src_p1_5_i),
  .irq1_src_p2_0_i(irq1_src_p2_0_i), .ext_irq_one_input_o(ext_irq_one_input_o),
  .pin_level_i(pin_level_i), .port_latch_i(port_latch_i),
  .port_direction_reg_i(port_direction_reg_i), .port_read_data_o(port_read_data_o),
  .i2c_rate_double_o(i2c_rate_double_o), .i2c_rate_half_o(i2c_rate_half_o),
  .sda_i(sda_i), .sda_delayed_o(sda_delayed_o), .pullup_en_o(pullup_en_o)
);

// ==== tb/pin_select_port_read_pullup_tb.sv ====
// Self-checking bench for the pin select block
`timescale 1ns/10ps
`include "pin_select_defs.vh"
module pin_select_port_read_pullup_tb;
  reg clk_i, reset_n_i, psel_i, penable_i, pwrite_i, sda_i, err;
  reg irq1_src_p1_7_i, irq1_src_p1_5_i, irq1_src_p2_0_i;
  reg [11:0] paddr_i;
  reg [31:0] pwdata_i, seed, rd;
  reg [3:0] pstrb_i, mn, mp;
  reg [39:0] pin_level_i, port_latch_i, port_direction_reg_i, pn, ln, dn, pp, lp, dp, ex;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, ext_irq_one_input_o, i2c_rate_double_o;
  wire i2c_rate_half_o, sda_delayed_o;
  wire [39:0] port_read_data_o, pullup_en_o;
  integer fails, comparisons, k, c, dly;
  reg [1:0] cd;
  reg [7:0] io_v, pu_v;
  reg sq [$];
  reg [11:0] at [0:2];
  reg [7:0] wt [0:2];
  reg [7:0] et [0:2];
  pin_select_port_read_pullup pin_select_port_read_pullup_inst
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq1_src_p1_7_i(irq1_src_p1_7_i), .irq1_src_p1_5_i(irq1_src_p1_5_i),
    .irq1_src_p2_0_i(irq1_src_p2_0_i), .ext_irq_one_input_o(ext_irq_one_input_o),
    .pin_level_i(pin_level_i), .port_latch_i(port_latch_i),
    .port_direction_reg_i(port_direction_reg_i), .port_read_data_o(port_read_data_o),
    .i2c_rate_double_o(i2c_rate_double_o), .i2c_rate_half_o(i2c_rate_half_o),
    .sda_i(sda_i), .sda_delayed_o(sda_delayed_o), .pullup_en_o(pullup_en_o)
  );
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
  endfunction
  // Pull-up groups per port; P4 has no enable here
  function [39:0] pu_map(input [7:0] p);
    pu_map = {8'h00, p[7], 1'b0, p[7], p[7], p[6], 1'b0, p[6], 1'b0, 5'h00, {3{p[4]}},
      {4{p[3]}}, {4{p[2]}}, {4{p[1]}}, {4{p[0]}}};
  endfunction
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Pready is taken at the rising edge itself; only the watchdog ends a wait
  task apb(input w, input [11:0] a, input [7:0] d, input [3:0] s, output [31:0] r,
    output e);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h000000, d};
      pstrb_i <= s;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
        @(posedge clk_i);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #100000;
    fails = fails + 1;
    close_out;
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    {reset_n_i, psel_i, penable_i, pwrite_i, sda_i, paddr_i, pwdata_i, pstrb_i} = 0;
    {irq1_src_p1_7_i, irq1_src_p1_5_i, irq1_src_p2_0_i} = 3'h0;
    {pin_level_i, port_latch_i, port_direction_reg_i, pp, lp, dp, mp} = 0;
    {fails, comparisons} = 0;
    seed = 32'h000025C7;
    at[0] = `IRQ_PIN_SEL_IDX << 2;
    at[1] = `IO_FUNC_SEL_IDX << 2;
    at[2] = `PULLUP_CTRL0_IDX << 2;
    {wt[0], wt[1], wt[2], et[0], et[1], et[2]} = 48'h259CDF0498DF;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (k = 0; k < 3; k = k + 1)
    begin
      apb(0, at[k], 8'h00, 4'hF, rd, err);
      chk(rd, 0);
      apb(1, at[k], wt[k], 4'hE, rd, err);
      apb(0, at[k], 8'h00, 4'hF, rd, err);
      chk(rd, 0);
      apb(1, at[k], wt[k], 4'h1, rd, err);
      apb(0, at[k], 8'h00, 4'hF, rd, err);
      chk({err, rd}, {1'b0, 24'h000000, et[k]});
    end
    apb(0, 12'h004, 8'h00, 4'hF, rd, err);
    chk({err, rd}, {1'b1, 32'h00000000});
    for (k = 0; k < 4; k = k + 1)
    begin
      cd = k % 3;
      io_v = {cd, k[1], k[0], k[0], 3'b000};
      seed = lfsr(seed);
      pu_v = seed[7:0] & 8'hDF;
      apb(1, at[0], {4'h0, 1'b0, cd, 1'b0}, 4'h1, rd, err);
      apb(1, at[1], io_v, 4'h1, rd, err);
      apb(1, at[2], pu_v, 4'h1, rd, err);
      dly = cd == 2'h0 ? 3 : cd == 2'h1 ? 11 : 19;
      sq.delete();
      for (c = 0; c < 40; c = c + 1)
      begin
        @(posedge clk_i);
        seed = lfsr(seed);
        pn = {seed[15:8], seed};
        seed = lfsr(seed);
        ln = {seed[23:16], seed};
        seed = lfsr(seed);
        dn = {seed[31:24], seed};
        seed = lfsr(seed);
        mn = seed[3:0];
        pin_level_i <= pn;
        port_latch_i <= ln;
        port_direction_reg_i <= dn;
        {irq1_src_p1_7_i, irq1_src_p1_5_i, irq1_src_p2_0_i, sda_i} <= mn;
        sq.push_back(mn[0]);
        #1;
        ex = io_v[3] ? pp : (pp & ~dp) | (lp & dp);
        ex[34] = dp[34] ? lp[34] : pp[34];
        if (c > 1)
        begin
          chk(ext_irq_one_input_o, cd == 2'h0 ? mp[3] : cd == 2'h1 ? mp[2] : mp[1]);
          chk(port_read_data_o, ex);
          chk(pullup_en_o, pu_map(pu_v) & ~dp);
          chk({i2c_rate_double_o, i2c_rate_half_o}, {io_v[4] & ~io_v[5], io_v[5] & ~io_v[4]});
        end
        if (sq.size() > dly)
          chk(sda_delayed_o, sq[sq.size() - 1 - dly]);
        {pp, lp, dp, mp} = {pn, ln, dn, mn};
      end
      apb(0, at[2], 8'h00, 4'hF, rd, err);
      chk(rd, pu_v);
    end
    close_out;
  end
endmodule // pin_select_port_read_pullup_tb
